// ---- verilog/counter_array_capture_compare_modules.sv ----
// Operation
// - edge bits 5/4 choose capture trigger
// - selected edge captures counter, sets flag
// - flag cleared only by software write
// - interrupt when flag and enable bit 0
// - pin level readable by software
// - timer mode flags on 16-bit equality
// - low write clears, high write sets comparator
// - fast output toggles pin per match
// - comparator off leaves pin unchanged outside pwm modes
// - frequency mode toggles, adds high byte
// - high byte zero counts as 256
// - frequency mode chosen by bits 2,1
// - frequency match flag on full equality
// - shared length from pwm bits 1-0
// - pwm select, bit 7 picks 16-bit
// - comparator off forces pwm low
// - pwm bit 7 maps reload registers
// - pwm bit 5 enables overflow interrupt
// - pwm match flags when comparator and match enabled
// - channel modes independent of shared length
// - 8-bit pwm reloads low from high
// - n-bit pwm overflow loads reload value
// - 16-bit pwm low on full overflow
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_compare_modules
(
   input  wire logic                core_clk,
   input  wire logic                arst_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   input  wire cc_pkg::counter_type counter,
   input  wire logic                channelPinIn,
   output logic                     channelPinOut,
   output logic                     channelPinOe,
   output logic                     channelIrq,
   output logic                     overflowIrq
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0]  mode_reg;
   logic [7:0]  pwmCfg_reg;
   logic [15:0] cmp_reg;
   logic [15:0] reload_reg;
   logic        event_reg;
   logic        ovfFlag_reg;
   logic        pin_reg;
   logic        pinDly_reg;
   logic        out_reg;
   logic [31:0] rdata_reg;

   logic wrAcc;
   logic rdSetup;
   logic mapped;
   assign wrAcc = psel && penable && pwrite;
   assign rdSetup = psel && !penable && !pwrite;
   assign mapped = paddr inside {cc_pkg::ModeAddr, cc_pkg::CmpLowAddr, cc_pkg::CmpHighAddr,
                                 cc_pkg::PwmCfgAddr, cc_pkg::StatusAddr, cc_pkg::CaptureAddr};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_reg;

   // ************************************************************
   // mode decode
   // ************************************************************
   cc_pkg::mode_type mode;
   logic compEn;
   logic matchEn;
   assign compEn  = mode_reg[cc_pkg::CompEnBit];
   assign matchEn = mode_reg[cc_pkg::MatchBit];

   always_comb
   begin
      mode = cc_pkg::ModeIdle;
      if (mode_reg[cc_pkg::RiseBit] || mode_reg[cc_pkg::FallBit])
         mode = cc_pkg::ModeCapture;
      else if (mode_reg[cc_pkg::ToggleBit] && mode_reg[cc_pkg::PwmSelBit])
         mode = cc_pkg::ModeFreq;
      else if (mode_reg[cc_pkg::ToggleBit])
         mode = cc_pkg::ModeFast;
      else if (mode_reg[cc_pkg::PwmSelBit])
         mode = mode_reg[cc_pkg::WidePwmBit] ? cc_pkg::ModePwm16 : cc_pkg::ModePwmN;
      else if (compEn && matchEn)
         mode = cc_pkg::ModeTimer;
   end

   // ************************************************************
   // counter comparisons
   // ************************************************************
   logic [1:0]  lenSel;
   logic [15:0] lenMask;
   logic        lenOvf;
   logic        fullMatch;
   logic        lowMatch;
   logic        nMatch;
   assign lenSel = pwmCfg_reg[1:0];
   always_comb
   begin
      unique case (lenSel)
         2'b00: lenMask = 16'h00ff;
         2'b01: lenMask = 16'h01ff;
         2'b10: lenMask = 16'h03ff;
         2'b11: lenMask = 16'h07ff;
      endcase
   end
   assign lenOvf    = counter.ovf[{1'b0, lenSel}];
   assign fullMatch = counter.tick && (counter.value == cmp_reg);
   assign lowMatch  = counter.tick && (counter.value[7:0] == cmp_reg[7:0]);
   assign nMatch    = counter.tick && ((counter.value & lenMask) == (cmp_reg & lenMask));

   // ************************************************************
   // pin sampling and edge detection
   // ************************************************************
   logic rise;
   logic fall;
   logic capture;
   // pin is synchronous; the delay stage holds the previous sample, so one new sample makes an edge
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_reg    <= 1'b0;
         pinDly_reg <= 1'b0;
      end
      else
      begin
         pin_reg    <= channelPinIn;
         pinDly_reg <= pin_reg;
      end
   end
   assign rise = pin_reg && !pinDly_reg;
   assign fall = !pin_reg && pinDly_reg;
   assign capture = (mode == cc_pkg::ModeCapture) &&
                    ((rise && mode_reg[cc_pkg::RiseBit]) || (fall && mode_reg[cc_pkg::FallBit]));

   // ************************************************************
   // event sources
   // ************************************************************
   logic matchEvent;
   always_comb
   begin
      unique case (mode)
         cc_pkg::ModeTimer:  matchEvent = fullMatch;
         cc_pkg::ModeFast:   matchEvent = compEn && matchEn && fullMatch;
         cc_pkg::ModeFreq:   matchEvent = matchEn && fullMatch;
         cc_pkg::ModePwmN:   matchEvent = compEn && matchEn &&
                                          (lenSel == 2'b00 ? lowMatch : nMatch);
         cc_pkg::ModePwm16:  matchEvent = compEn && matchEn && fullMatch;
         default:            matchEvent = 1'b0;
      endcase
   end

   // ************************************************************
   // register writes
   // ************************************************************
   logic viewReload;
   assign viewReload = pwmCfg_reg[cc_pkg::ReloadView];

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         mode_reg <= cc_pkg::ModeReset;
      else if (wrAcc && paddr == cc_pkg::ModeAddr)
         mode_reg <= pwdata[7:0];
      else if (wrAcc && paddr == cc_pkg::CmpLowAddr)
         mode_reg[cc_pkg::CompEnBit] <= 1'b0;
      else if (wrAcc && paddr == cc_pkg::CmpHighAddr)
         mode_reg[cc_pkg::CompEnBit] <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         pwmCfg_reg <= cc_pkg::PwmReset;
      else if (wrAcc && paddr == cc_pkg::PwmCfgAddr)
      begin
         // the flag bit and bits 4:2 hold no state here
         pwmCfg_reg[cc_pkg::ReloadView]  <= pwdata[cc_pkg::ReloadView];
         pwmCfg_reg[cc_pkg::OvfIrqEnBit] <= pwdata[cc_pkg::OvfIrqEnBit];
         pwmCfg_reg[1:0]                 <= pwdata[1:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reload_reg <= cc_pkg::CmpReset;
      else if (wrAcc && viewReload && paddr == cc_pkg::CmpLowAddr)
         reload_reg[7:0] <= pwdata[7:0];
      else if (wrAcc && viewReload && paddr == cc_pkg::CmpHighAddr)
         reload_reg[15:8] <= pwdata[7:0];
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         cmp_reg <= cc_pkg::CmpReset;
      else if (capture)
         cmp_reg <= counter.value;
      else if (wrAcc && !viewReload && paddr == cc_pkg::CmpLowAddr)
         cmp_reg[7:0] <= pwdata[7:0];
      else if (wrAcc && !viewReload && paddr == cc_pkg::CmpHighAddr)
         cmp_reg[15:8] <= pwdata[7:0];
      // add high byte, 8-bit wrap makes zero act as 256
      else if (mode == cc_pkg::ModeFreq && compEn && lowMatch)
         cmp_reg[7:0] <= cmp_reg[7:0] + cmp_reg[15:8];
      else if (mode == cc_pkg::ModePwmN && lenSel == 2'b00 && counter.ovf[0])
         cmp_reg[7:0] <= cmp_reg[15:8];
      else if (mode == cc_pkg::ModePwmN && lenSel != 2'b00 && lenOvf)
         cmp_reg <= (cmp_reg & ~lenMask) | (reload_reg & lenMask);
   end

   // ************************************************************
   // flags, set beats clear
   // ************************************************************
   logic clrEvent;
   logic clrOvf;
   assign clrEvent = wrAcc && paddr == cc_pkg::StatusAddr && pwdata[cc_pkg::EventFlagBit];
   assign clrOvf   = wrAcc && paddr == cc_pkg::PwmCfgAddr && !pwdata[cc_pkg::OvfFlagBit];

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         event_reg <= 1'b0;
      else if (capture || matchEvent)
         event_reg <= 1'b1;
      else if (clrEvent)
         event_reg <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         ovfFlag_reg <= 1'b0;
      else if (lenOvf)
         ovfFlag_reg <= 1'b1;
      else if (clrOvf)
         ovfFlag_reg <= 1'b0;
   end

   assign channelIrq = event_reg && mode_reg[cc_pkg::IrqEnBit];
   assign overflowIrq = ovfFlag_reg && pwmCfg_reg[cc_pkg::OvfIrqEnBit];

   // ************************************************************
   // output pin
   // ************************************************************
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         out_reg <= 1'b0;
      else
      begin
         unique case (mode)
            cc_pkg::ModeFast:
               if (compEn && fullMatch)
                  out_reg <= !out_reg;
            cc_pkg::ModeFreq:
               if (compEn && lowMatch)
                  out_reg <= !out_reg;
            // n-bit pwm, low wins at overflow
            cc_pkg::ModePwmN:
               if (!compEn || lenOvf)
                  out_reg <= 1'b0;
               else if (lenSel == 2'b00 ? lowMatch : nMatch)
                  out_reg <= 1'b1;
            cc_pkg::ModePwm16:
               if (!compEn || counter.ovf[8])
                  out_reg <= 1'b0;
               else if (fullMatch)
                  out_reg <= 1'b1;
            default:
               out_reg <= out_reg;
         endcase
      end
   end
   assign channelPinOut = out_reg;
   // pin driven only in output modes
   assign channelPinOe  = (mode == cc_pkg::ModeFast) || (mode == cc_pkg::ModeFreq) ||
                          (mode == cc_pkg::ModePwmN) || (mode == cc_pkg::ModePwm16);

   // ************************************************************
   // read views of the status and pwm configuration words
   // ************************************************************
   logic [7:0] pwmCfgRead;
   logic [7:0] statusRead;
   always_comb
   begin
      pwmCfgRead                       = pwmCfg_reg;
      pwmCfgRead[cc_pkg::OvfFlagBit]   = ovfFlag_reg;
      statusRead                       = 8'h00;
      statusRead[cc_pkg::EventFlagBit] = event_reg;
      statusRead[cc_pkg::PinLevelBit]  = pin_reg;
   end

   // ************************************************************
   // read data, registered in the setup phase
   // ************************************************************
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_reg <= 32'h00000000;
      else if (rdSetup)
      begin
         unique case (paddr)
            cc_pkg::ModeAddr:    rdata_reg <= {24'h000000, mode_reg};
            cc_pkg::CmpLowAddr:  rdata_reg <= {24'h000000, viewReload ? reload_reg[7:0] : cmp_reg[7:0]};
            cc_pkg::CmpHighAddr: rdata_reg <= {24'h000000, viewReload ? reload_reg[15:8] : cmp_reg[15:8]};
            cc_pkg::PwmCfgAddr:  rdata_reg <= {24'h000000, pwmCfgRead};
            cc_pkg::StatusAddr:  rdata_reg <= {24'h000000, statusRead};
            cc_pkg::CaptureAddr: rdata_reg <= {16'h0000, cmp_reg};
            default:             rdata_reg <= 32'h00000000;
         endcase
      end
   end
endmodule // counter_array_capture_compare_modules
`default_nettype wire

// ---- verilog/cc_pkg.sv ----
`default_nettype none
package cc_pkg;
   // ************************************************************
   // register map, byte addresses on the apb bus
   // ************************************************************
   localparam logic [7:0] ModeAddr     = 8'h00;
   localparam logic [7:0] CmpLowAddr   = 8'h04;
   localparam logic [7:0] CmpHighAddr  = 8'h08;
   localparam logic [7:0] PwmCfgAddr   = 8'h0c;
   localparam logic [7:0] StatusAddr   = 8'h10;
   localparam logic [7:0] CaptureAddr  = 8'h14;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int IrqEnBit     = 0;
   localparam int PwmSelBit    = 1;
   localparam int ToggleBit    = 2;
   localparam int MatchBit     = 3;
   localparam int FallBit      = 4;
   localparam int RiseBit      = 5;
   localparam int CompEnBit    = 6;
   localparam int WidePwmBit   = 7;
   localparam int ReloadView   = 7;
   localparam int OvfIrqEnBit  = 5;
   localparam int OvfFlagBit   = 6;
   localparam int EventFlagBit = 0;
   localparam int PinLevelBit  = 1;

   localparam logic [7:0]  ModeReset   = 8'h00;
   localparam logic [7:0]  PwmReset    = 8'h00;
   localparam logic [15:0] CmpReset    = 16'h0000;

   // ************************************************************
   // counter inputs shared by every channel
   // ************************************************************
   typedef struct packed {
      logic [15:0] value;
      logic        tick;
      logic [8:0]  ovf;   // ovf[0]=bit 8 ... ovf[7]=bit 15, ovf[8]=bit 16
   } counter_type;

   typedef enum logic [2:0] {
      ModeIdle, ModeCapture, ModeTimer, ModeFast, ModeFreq, ModePwmN, ModePwm16
   } mode_type;
endpackage
`default_nettype wire

// ---- test/cc_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cc_checker_properties
(
   input wire logic                core_clk,
   input wire logic                arst_n,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic                pready,
   input wire logic [31:0]         prdata,
   input wire logic                pslverr,
   input wire cc_pkg::counter_type counter,
   input wire logic                channelPinOut,
   input wire logic                channelIrq,
   input wire logic                overflowIrq
);
   wire logic wr  = psel && penable && pwrite;
   wire logic bad = psel && penable && (paddr > cc_pkg::CaptureAddr || paddr[1:0] != 2'b00);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ************************************************************
   // bus answer, flag lifetimes and pin causes
   // ************************************************************
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_slv_set; bad |-> pslverr; endproperty
   a_slv_set: assert property (p_slv_set) else $error("no slave error on unmapped access");
   property p_slv_only; pslverr |-> bad; endproperty
   a_slv_only: assert property (p_slv_only) else $error("slave error on mapped access");
   property p_rd_hold; !$stable(prdata) |-> $past(psel && !penable); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside setup");
   // flags only fall by a software write
   property p_irq_fall; $fell(channelIrq) |-> $past(wr); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("channel irq fell without write");
   property p_ovf_fall; $fell(overflowIrq) |-> $past(wr); endproperty
   a_ovf_fall: assert property (p_ovf_fall) else $error("overflow irq fell without write");
   property p_ovf_rise; $rose(overflowIrq) |-> $past(|counter.ovf[3:0]) || $past(counter.ovf[3:0], 2) != 4'h0
      || $past(wr) || $past(wr, 2); endproperty
   a_ovf_rise: assert property (p_ovf_rise) else $error("overflow irq rose without cause");
   property p_pin_cause; $changed(channelPinOut) |-> $past(counter.tick) || $past(counter.tick, 2)
      || $past(wr) || $past(wr, 2); endproperty
   a_pin_cause: assert property (p_pin_cause) else $error("pin moved without tick or write");
endmodule // cc_checker_properties
bind counter_array_capture_compare_modules cc_checker_properties u_cc_checker_properties
   (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .counter,
    .channelPinOut, .channelIrq, .overflowIrq);
`default_nettype wire

// ---- test/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_source
(
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic reqLevel,
   input  wire logic pinOut,
   input  wire logic pinOe,
   output logic      pinWire
);
   logic       srcLevel;
   logic [1:0] holdCount;
   // three clock hold
   // a new level is taken only once the old one has stood three clocks
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         srcLevel  <= 1'b0;
         holdCount <= 2'd2;
      end
      else if (reqLevel != srcLevel && holdCount == 2'd2)
      begin
         srcLevel  <= reqLevel;
         holdCount <= 2'd0;
      end
      else if (holdCount != 2'd2)
         holdCount <= holdCount + 2'd1;
   end
   assign pinWire = pinOe ? pinOut : srcLevel;
endmodule // pin_source
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic                core_clk, arst_n, psel, penable, pwrite, pready, pslverr, hit;
   logic                pinOut, pinOe, pinWire, reqLevel, channelIrq, overflowIrq;
   logic [7:0]          paddr;
   logic [15:0]         r;
   logic [31:0]         pwdata, prdata, expNow;
   logic [31:0]         expQ[$];
   cc_pkg::counter_type counter;
   int                  err_count, n_compared, cycles;
   int                  seed = 32'h25c4d09a;

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   counter_array_capture_compare_modules u_counter_array_capture_compare_modules
      (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .counter,
       .channelPinIn(pinWire), .channelPinOut(pinOut), .channelPinOe(pinOe), .channelIrq, .overflowIrq);
   pin_source u_pin_source (.core_clk, .arst_n, .reqLevel, .pinOut, .pinOe, .pinWire);

   // ************************************************************
   // bus, counter and pin tasks
   // ************************************************************
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task wcmp(input logic [15:0] c);
      wr(cc_pkg::CmpLowAddr, c[7:0]);
      wr(cc_pkg::CmpHighAddr, c[15:8]);
   endtask
   // one counter advance, then the pin is looked at once it has settled
   task tkc(input logic [15:0] v, input logic [8:0] o, input logic e);
      @(posedge core_clk);
      counter <= '{value: v, tick: 1'b1, ovf: o};
      @(posedge core_clk);
      counter.tick <= 1'b0;
      counter.ovf <= 9'h0;
      repeat (2) @(posedge core_clk);
      `CHK("channelPinOut", e, pinOut)
   endtask
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // read results are matched against the oldest note
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         err_count++;
         end_of_test();
      end
      else if (psel && penable && !pwrite && pready === 1'b1)
      begin
         expNow = expQ.pop_front();
         `CHK("prdata", expNow, prdata)
      end
   end

   initial
   begin
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; reqLevel = 1'b0; counter = '0;
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int a = 0; a <= 24; a += 4) rd(a[7:0], 32'h0);
      wr(cc_pkg::ModeAddr, 8'h40);
      wr(cc_pkg::CmpLowAddr, 8'h12);
      rd(cc_pkg::ModeAddr, 32'h00);
      wr(cc_pkg::CmpHighAddr, 8'h34);
      rd(cc_pkg::ModeAddr, 32'h40);
      for (int m = 1; m < 4; m++)
      begin
         wr(cc_pkg::ModeAddr, 8'(m << 4) | 8'h01);
         for (int e = 1; e >= 0; e--)
         begin
            r = 16'($random(seed));
            counter.value <= r;
            wr(cc_pkg::StatusAddr, 8'h01);
            @(posedge core_clk);
            reqLevel <= e[0];
            repeat (6) @(posedge core_clk);
            hit = e ? m[1] : m[0];
            rd(cc_pkg::StatusAddr, {30'h0, e[0], hit});
            `CHK("channelIrq", hit, channelIrq)
            `CHK("channelPinOe", 1'b0, pinOe)
            if (hit) rd(cc_pkg::CaptureAddr, {16'h0, r});
         end
      end
      r = 16'($random(seed)) | 16'h0001;
      wr(cc_pkg::ModeAddr, 8'h49);
      wcmp(r);
      wr(cc_pkg::StatusAddr, 8'h01);
      tkc(r - 16'd1, 9'h0, 1'b0);
      rd(cc_pkg::StatusAddr, 32'h0);
      tkc(r, 9'h0, 1'b0);
      repeat (20) @(posedge core_clk);
      rd(cc_pkg::StatusAddr, 32'h1);
      `CHK("channelIrq", 1'b1, channelIrq)
      wr(cc_pkg::StatusAddr, 8'h01);
      wr(cc_pkg::ModeAddr, 8'h4c);
      wcmp(r);
      tkc(r, 9'h0, 1'b1);
      wr(cc_pkg::CmpLowAddr, r[7:0]);
      tkc(r, 9'h0, 1'b1);
      wr(cc_pkg::CmpHighAddr, r[15:8]);
      tkc(r, 9'h0, 1'b0);
      rd(cc_pkg::StatusAddr, 32'h1);
      `CHK("channelIrq", 1'b0, channelIrq)
      wr(cc_pkg::ModeAddr, 8'h46);
      wcmp(16'h0310);
      tkc(16'h0010, 9'h0, 1'b1);
      tkc(16'h0012, 9'h0, 1'b1);
      tkc(16'h0013, 9'h0, 1'b0);
      wcmp(16'h0020);
      tkc(16'h0020, 9'h0, 1'b1);
      tkc(16'h0120, 9'h0, 1'b0);
      wr(cc_pkg::StatusAddr, 8'h01);
      wr(cc_pkg::ModeAddr, 8'h4e);
      tkc(16'h0120, 9'h0, 1'b1);
      rd(cc_pkg::StatusAddr, 32'h2);
      tkc(16'h0020, 9'h0, 1'b0);
      rd(cc_pkg::StatusAddr, 32'h1);
      for (int n = 0; n < 4; n++)
      begin
         wr(cc_pkg::PwmCfgAddr, 8'h20 | 8'(n));
         wr(cc_pkg::ModeAddr, 8'h42);
         wcmp(16'h0005);
         tkc(16'h0005 | (16'h1 << (8 + n)), 9'h0, 1'b1);
         tkc(16'h0000, 9'h1 << ((n + 1) % 4), 1'b1);
         `CHK("overflowIrq", 1'b0, overflowIrq)
         tkc(16'h0000, 9'h1 << n, 1'b0);
         `CHK("overflowIrq", 1'b1, overflowIrq)
         rd(cc_pkg::PwmCfgAddr, 32'h60 | n);
         wr(cc_pkg::PwmCfgAddr, 8'h20 | 8'(n));
      end
      wr(cc_pkg::PwmCfgAddr, 8'h00);
      wcmp(16'h4005);
      tkc(16'h0005, 9'h0, 1'b1);
      tkc(16'h0000, 9'h1, 1'b0);
      tkc(16'h0005, 9'h0, 1'b0);
      tkc(16'h0040, 9'h0, 1'b1);
      wr(cc_pkg::CmpLowAddr, 8'h40);
      tkc(16'h0040, 9'h0, 1'b0);
      wr(cc_pkg::PwmCfgAddr, 8'h01);
      wcmp(16'h0030);
      wr(cc_pkg::PwmCfgAddr, 8'h81);
      wcmp(16'h0107);
      wr(cc_pkg::PwmCfgAddr, 8'h01);
      wr(cc_pkg::ModeAddr, 8'h42);
      tkc(16'h0030, 9'h0, 1'b1);
      tkc(16'h0000, 9'h2, 1'b0);
      tkc(16'h0030, 9'h0, 1'b0);
      tkc(16'h0107, 9'h0, 1'b1);
      wr(cc_pkg::ModeAddr, 8'hca);
      wcmp(r);
      wr(cc_pkg::StatusAddr, 8'h01);
      tkc(r, 9'h0, 1'b1);
      rd(cc_pkg::StatusAddr, 32'h3);
      `CHK("channelPinOe", 1'b1, pinOe)
      tkc(16'h0000, 9'h00f, 1'b1);
      tkc(16'h0000, 9'h100, 1'b0);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
